// ==== core/cci_defines.svh ====
// offsets, fields, reset values and opcodes of the config cache invalidation block
`ifndef CCI_DEFINES_SVH
`define CCI_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CCI_OFS_STREAM  8'h00
`define CCI_OFS_SUBIDX  8'h04
`define CCI_OFS_VMTAG   8'h08
`define CCI_OFS_CMD     8'h0c
`define CCI_OFS_STATUS  8'h10
`define CCI_OFS_CAPS    8'h14
`define CCI_OFS_FILL    8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CCI_CMD_OP_HI    7
`define CCI_CMD_SECSEL   8
`define CCI_CMD_LEAF     9
`define CCI_CMD_SQUEUE   10
`define CCI_CMD_RANGE_LO 16
`define CCI_CMD_RANGE_HI 20
`define CCI_ST_ERR       1
`define CCI_FILL_SEC     3
`define CCI_FILL_SLOT_LO 8
`define CCI_FILL_SLOT_HI 10

// ----------------------------------------------------------------
// reset values, widths and entry count
// ----------------------------------------------------------------
`define CCI_CAPS_RST     9'h14f
`define CCI_SUB_W        20
`define CCI_VM_W         16
`define CCI_ENTRIES      8

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define CCI_OP_STREAM       8'h03
`define CCI_OP_STREAM_RANGE 8'h04
`define CCI_OP_CONTEXT      8'h05
`define CCI_OP_CONTEXT_ALL  8'h06
`define CCI_OP_PART_MAP     8'h07
`define CCI_OP_ALL       8'h08
`define CCI_OP_SYNC      8'h46
`define CCI_RANGE_ALL    5'h1f

`endif

// ==== core/cci_pkg.sv ====
// types of the config cache invalidation block
package cci_pkg;

  typedef enum logic [2:0] {
    CCI_IDLE = 3'b001,
    CCI_EXEC = 3'b010,
    CCI_SYNC = 3'b100
  } cci_state_t;

  typedef enum logic [2:0] {
    CCI_K_STREAM     = 3'h0,
    CCI_K_L1_STREAM  = 3'h1,
    CCI_K_CONTEXT    = 3'h2,
    CCI_K_L1_CONTEXT = 3'h3,
    CCI_K_VM_DATA    = 3'h4,
    CCI_K_PMAP       = 3'h5
  } cci_kind_t;

endpackage

// ==== core/cci_config_inval.sv ====
// config cache with invalidation command engine behind an axi4-lite slave
// Contract
// (R1) single stream command drops stream entry
// (R2) leaf zero also drops level-one stream descriptors
// (R3) leaf one keeps level-one stream descriptors
// (R4) linear table entries dropped for any leaf
// (R5) single stream command drops its context descriptors
// (R6) single stream command drops vm structure data
// (R7) software issues separate tlb invalidation
// (R8) range covers aligned block of indices
// (R9) range 31 drops whole security state
// (R10) range drops descriptors, contexts and vm data
// (R11) context command matches table index
// (R12) sub-index zero hits table entry zero
// (R13) out of range sub-index does nothing
// (R14) context leaf zero drops level-one descriptor
// (R15) context commands illegal without stage one
// (R16) software covers every sharing stream
// (R17) whole-stream context command drops all contexts
// (R18) software follows with tlb invalidation
// (R19) partition map command drops map entries
// (R20) partition map illegal cases raise error
// (R21) software follows partition map sequence
// (R22) software supplies stage2 vm tag
// (R23) secure selector from non-secure queue illegal
// (R24) sync waits for earlier invalidations
// (R25) invalidation applied atomically in one cycle
`timescale 1ns/10ps
`include "cci_defines.svh"

module cci_config_inval
  import cci_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int N = `CCI_ENTRIES;

  logic                  aw_hold_ff;
  logic [7:0]            aw_addr_ff;
  logic                  w_hold_ff;
  logic [31:0]           w_data_ff;
  logic [3:0]            w_strb_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  logic                  rvalid_ff;
  logic [1:0]            rresp_ff;
  logic [31:0]           rdata_ff;
  logic                  wr_fire;
  logic                  wr_ok;
  logic                  wr_busy_reg;
  logic [31:0]           stream_ff;
  logic [`CCI_SUB_W-1:0] subidx_ff;
  logic [`CCI_VM_W-1:0]  vmtag_ff;
  logic [31:0]           cmd_ff;
  logic [8:0]            caps_ff;
  logic                  err_ff;
  logic [7:0]            err_op_ff;
  logic [15:0]           sync_cnt_ff;
  cci_state_t            state_ff;
  cci_state_t            nxt_state;
  logic                  cmd_wr;
  logic                  fill_wr;
  logic                  illegal;
  logic [7:0]            op;
  logic                  sec_sel;
  logic                  leaf;
  logic [4:0]            rng;
  logic [32:0]           blk;
  logic [31:0]           amask;
  logic [N-1:0]          vld_ff;
  logic [N-1:0]          hit;
  logic [31:0]           rd_val;
  logic                  rd_ok;

  assign op   = cmd_ff[`CCI_CMD_OP_HI:0];
  assign sec_sel = cmd_ff[`CCI_CMD_SECSEL];
  assign leaf = cmd_ff[`CCI_CMD_LEAF];
  assign rng  = (op == `CCI_OP_ALL) ? `CCI_RANGE_ALL
                                    : cmd_ff[`CCI_CMD_RANGE_HI:`CCI_CMD_RANGE_LO];

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign wr_fire       = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_busy_reg   = (aw_addr_ff == `CCI_OFS_CMD) || (aw_addr_ff == `CCI_OFS_FILL);
  assign wr_ok = ((aw_addr_ff == `CCI_OFS_STREAM) || (aw_addr_ff == `CCI_OFS_SUBIDX) ||
                  (aw_addr_ff == `CCI_OFS_VMTAG) || (aw_addr_ff == `CCI_OFS_STATUS) ||
                  (aw_addr_ff == `CCI_OFS_CAPS) || wr_busy_reg) &&
                 !(wr_busy_reg && state_ff != CCI_IDLE);
  assign cmd_wr  = wr_fire && wr_ok && (aw_addr_ff == `CCI_OFS_CMD);
  assign fill_wr = wr_fire && wr_ok && (aw_addr_ff == `CCI_OFS_FILL);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_hold_ff  <= 1'b0;
      w_data_ff  <= 32'h0;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_ok ? 2'h0 : 2'h2;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stream_ff <= 32'h0;
      subidx_ff <= '0;
      vmtag_ff  <= '0;
      cmd_ff    <= 32'h0;
      caps_ff   <= `CCI_CAPS_RST;
    end else if (wr_fire && wr_ok && w_strb_ff == 4'hf) begin
      if (aw_addr_ff == `CCI_OFS_STREAM) begin
        stream_ff <= w_data_ff;
      end else if (aw_addr_ff == `CCI_OFS_SUBIDX) begin
        subidx_ff <= w_data_ff[`CCI_SUB_W-1:0];
      end else if (aw_addr_ff == `CCI_OFS_VMTAG) begin
        vmtag_ff <= w_data_ff[`CCI_VM_W-1:0];
      end else if (aw_addr_ff == `CCI_OFS_CMD) begin
        cmd_ff <= w_data_ff;
      end else if (aw_addr_ff == `CCI_OFS_CAPS) begin
        caps_ff <= w_data_ff[8:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // command legality
  // ----------------------------------------------------------------
  // (R15) (R20) (R23) refused command cases
  assign illegal = (sec_sel && !cmd_ff[`CCI_CMD_SQUEUE]) ||
                   ((op == `CCI_OP_CONTEXT || op == `CCI_OP_CONTEXT_ALL) && !caps_ff[0]) ||
                   (op == `CCI_OP_PART_MAP && (!caps_ff[1] || !caps_ff[sec_sel ? 3 : 2])) ||
                   (op != `CCI_OP_STREAM && op != `CCI_OP_STREAM_RANGE &&
                    op != `CCI_OP_CONTEXT && op != `CCI_OP_CONTEXT_ALL &&
                    op != `CCI_OP_PART_MAP && op != `CCI_OP_ALL && op != `CCI_OP_SYNC);

  // ----------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CCI_IDLE: nxt_state = cmd_wr ? CCI_EXEC : CCI_IDLE;
      // (R24) sync only after invalidation applied
      CCI_EXEC: nxt_state = (op == `CCI_OP_SYNC && !illegal) ? CCI_SYNC : CCI_IDLE;
      CCI_SYNC: nxt_state = CCI_IDLE;
      default:  nxt_state = CCI_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= CCI_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_ff      <= 1'b0;
      err_op_ff   <= 8'h00;
      sync_cnt_ff <= 16'h0;
    end else begin
      // error set wins over software clear
      if (state_ff == CCI_EXEC && illegal) begin
        err_ff    <= 1'b1;
        err_op_ff <= op;
      end else if (wr_fire && aw_addr_ff == `CCI_OFS_STATUS && w_data_ff[`CCI_ST_ERR]) begin
        err_ff <= 1'b0;
      end
      if (state_ff == CCI_SYNC) begin
        sync_cnt_ff <= sync_cnt_ff + 16'h1;
      end
    end
  end

  // (R8) aligned block mask
  assign blk   = (33'h1 << ({1'b0, rng} + 6'h1)) - 33'h1;
  // (R9) range 31 clears the whole mask
  assign amask = ~blk[31:0];

  // ----------------------------------------------------------------
  // cache entries
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ent
      cci_kind_t             kind_ff;
      logic                  sec_ff;
      logic [31:0]           sid_ff;
      logic [`CCI_SUB_W-1:0] ssid_ff;
      logic [`CCI_VM_W-1:0]  vm_ff;
      logic                  sid_eq;
      logic                  in_rng;
      assign sid_eq = vld_ff[g] && (sec_ff == sec_sel) && (sid_ff == stream_ff);
      assign in_rng = vld_ff[g] && (sec_ff == sec_sel) &&
                      ((sid_ff & amask) == (stream_ff & amask));
      always_comb begin
        hit[g] = 1'b0;
        if (op == `CCI_OP_STREAM) begin
          // (R1) (R4) (R5) (R6) entry, contexts and vm data
          // (R2) (R3) level-one descriptor only on leaf zero
          hit[g] = sid_eq && (kind_ff != CCI_K_PMAP) &&
                   (kind_ff != CCI_K_L1_STREAM || !leaf);
        end else if (op == `CCI_OP_STREAM_RANGE || op == `CCI_OP_ALL) begin
          // (R10) all structures but partition map entries in the block
          hit[g] = in_rng && (kind_ff != CCI_K_PMAP);
        end else if (op == `CCI_OP_CONTEXT) begin
          // (R11) (R12) (R13) exact table index match
          // (R14) level-one context on leaf zero
          hit[g] = sid_eq && ((kind_ff == CCI_K_CONTEXT && ssid_ff == subidx_ff) ||
                              (kind_ff == CCI_K_L1_CONTEXT && !leaf));
        end else if (op == `CCI_OP_CONTEXT_ALL) begin
          // (R17) every context of the stream
          hit[g] = sid_eq && (kind_ff == CCI_K_CONTEXT || kind_ff == CCI_K_L1_CONTEXT);
        end else if (op == `CCI_OP_PART_MAP) begin
          // (R19) partition map by vm tag
          hit[g] = vld_ff[g] && kind_ff == CCI_K_PMAP && sec_ff == sec_sel && vm_ff == vmtag_ff;
        end
      end

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          vld_ff[g] <= 1'b0;
          kind_ff   <= CCI_K_STREAM;
          sec_ff    <= 1'b0;
          sid_ff    <= 32'h0;
          ssid_ff   <= '0;
          vm_ff     <= '0;
        end else if (fill_wr &&
                     w_data_ff[`CCI_FILL_SLOT_HI:`CCI_FILL_SLOT_LO] == 3'(g)) begin
          vld_ff[g] <= 1'b1;
          kind_ff   <= cci_kind_t'(w_data_ff[2:0]);
          sec_ff    <= w_data_ff[`CCI_FILL_SEC];
          sid_ff    <= stream_ff;
          ssid_ff   <= subidx_ff;
          vm_ff     <= vmtag_ff;
        // (R25) all hits cleared on one edge
        end else if (state_ff == CCI_EXEC && !illegal && hit[g]) begin
          vld_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (s_axi_araddr[7:2] == `CCI_OFS_STREAM >> 2) begin
      rd_val = stream_ff;
    end else if (s_axi_araddr[7:2] == `CCI_OFS_SUBIDX >> 2) begin
      rd_val = {12'h0, subidx_ff};
    end else if (s_axi_araddr[7:2] == `CCI_OFS_VMTAG >> 2) begin
      rd_val = {16'h0, vmtag_ff};
    end else if (s_axi_araddr[7:2] == `CCI_OFS_CMD >> 2) begin
      rd_val = cmd_ff;
    end else if (s_axi_araddr[7:2] == `CCI_OFS_STATUS >> 2) begin
      rd_val = {sync_cnt_ff, err_op_ff, 6'h0, err_ff, state_ff != CCI_IDLE};
    end else if (s_axi_araddr[7:2] == `CCI_OFS_CAPS >> 2) begin
      rd_val = {23'h0, caps_ff};
    end else if (s_axi_araddr[7:2] == `CCI_OFS_FILL >> 2) begin
      rd_val = {24'h0, vld_ff};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= 2'h0;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_val;
      rresp_ff  <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule // cci_config_inval

// ==== tb/cci_config_inval_assertions.sv ====
// bus-level checker bound to the config cache invalidation block
`timescale 1ns/10ps

module cci_config_inval_assertions (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response missing");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before taken");
  AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  AST_RD_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h06
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_WR_UNMAPPED: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && s_axi_awaddr[7:2] > 6'h06 |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
endmodule // cci_config_inval_assertions

bind cci_config_inval cci_config_inval_assertions u_cci_config_inval_assertions (
  .core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== tb/tb_cci_config_inval.sv ====
// self-checking bench for the config cache invalidation block
`timescale 1ns/10ps
`include "cci_defines.svh"

module tb_cci_config_inval;
  logic        core_clk = 1'b0, arst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [31:0] rnd = 32'h92a203df;
  int          errors = 0, checked = 0, cycles = 0;

  always #10 core_clk = ~core_clk;

  cci_config_inval u_cci_config_inval (.core_clk(core_clk), .arst_n(arst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                    input logic [1:0] eb);
    logic done;
    @(posedge core_clk);
    exp_b.push_back(eb);
    rnd = xs(rnd);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= rnd[0];
    done = 1'b0;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_bready) s_axi_bready <= 1'b1;
      else if (s_axi_bvalid) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    @(posedge core_clk);
    exp_r.push_back({er, ed});
    rnd = xs(rnd);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= rnd[1];
    done = 1'b0;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_rready) s_axi_rready <= 1'b1;
      else if (s_axi_rvalid) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  // monitor: oldest note against each answer
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (s_axi_bvalid && s_axi_bready) check("bresp", {32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
    cycles++;
    if (cycles == 40000) begin
      errors++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // cache scenarios
  // ----------------------------------------------------------------
  // slots: entry, l1 stream, ctx sub3, l1 ctx, vm data, pmap (all stream 5), entry 6, secure 5
  task automatic fill_all();
    logic [2:0] kinds[8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h0};
    for (int i = 0; i < 8; i++) begin
      wr(`CCI_OFS_STREAM, (i == 6) ? 32'h6 : 32'h5, 4'hf, 2'h0);
      wr(`CCI_OFS_SUBIDX, 32'h3, 4'hf, 2'h0);
      wr(`CCI_OFS_VMTAG, 32'h5, 4'hf, 2'h0);
      wr(`CCI_OFS_FILL, {21'h0, i[2:0], 4'h0, (i == 7), kinds[i]}, 4'hf, 2'h0);
    end
  endtask

  task automatic run_case(input logic [31:0] cmd, input logic [31:0] sid,
                          input logic [31:0] sub, input logic [7:0] mask, input logic err);
    fill_all();
    wr(`CCI_OFS_STREAM, sid, 4'hf, 2'h0);
    wr(`CCI_OFS_SUBIDX, sub, 4'hf, 2'h0);
    wr(`CCI_OFS_VMTAG, 32'h5, 4'hf, 2'h0);
    wr(`CCI_OFS_CMD, cmd, 4'hf, 2'h0);
    rd(`CCI_OFS_FILL, {24'h0, mask}, 2'h0);
    if (err) begin
      rd(`CCI_OFS_STATUS, {16'h1, cmd[7:0], 8'h02}, 2'h0);
      wr(`CCI_OFS_STATUS, 32'h2, 4'hf, 2'h0);
    end
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(`CCI_OFS_CAPS, 32'h14f, 2'h0);
    rd(`CCI_OFS_STATUS, 32'h0, 2'h0);
    rd(`CCI_OFS_FILL, 32'h0, 2'h0);
    rd(8'h1c, 32'h0, 2'h2);
    wr(8'h20, 32'h1, 4'hf, 2'h2);
    wr(`CCI_OFS_CAPS, 32'h0, 4'h3, 2'h0);
    rd(`CCI_OFS_CAPS, 32'h14f, 2'h0);
    wr(`CCI_OFS_CMD, 32'h46, 4'hf, 2'h0);
    rd(`CCI_OFS_STATUS, 32'h0001_0000, 2'h0);
    rnd = xs(rnd);
    run_case(32'h003, 32'h5, 32'h0, 8'he0, 1'b0);
    run_case(32'h203, 32'h5, 32'h0, 8'he2, 1'b0);
    run_case(32'h0_0004, {31'h2, rnd[0]}, 32'h0, 8'he0, 1'b0);
    run_case(32'h1_0004, {30'h1, rnd[1:0]}, 32'h0, 8'ha0, 1'b0);
    run_case(32'h1f_0004, rnd, 32'h0, 8'ha0, 1'b0);
    run_case(32'h1f_0504, rnd, 32'h0, 8'h7f, 1'b0);
    run_case(32'h008, rnd, 32'h0, 8'ha0, 1'b0);
    run_case(32'h005, 32'h5, 32'h3, 8'hf3, 1'b0);
    run_case(32'h205, 32'h5, 32'h3, 8'hfb, 1'b0);
    run_case(32'h205, 32'h5, 32'h0, 8'hff, 1'b0);
    wr(`CCI_OFS_FILL, 32'h0000_0202, 4'hf, 2'h0);
    wr(`CCI_OFS_CMD, 32'h205, 4'hf, 2'h0);
    rd(`CCI_OFS_FILL, 32'hfb, 2'h0);
    run_case(32'h006, 32'h5, 32'h0, 8'hf3, 1'b0);
    run_case(32'h007, 32'h0, 32'h0, 8'hdf, 1'b0);
    run_case(32'h103, 32'h5, 32'h0, 8'hff, 1'b1);
    run_case(32'h001, 32'h5, 32'h0, 8'hff, 1'b1);
    wr(`CCI_OFS_CAPS, 32'h14e, 4'hf, 2'h0);
    run_case(32'h005, 32'h5, 32'h3, 8'hff, 1'b1);
    run_case(32'h006, 32'h5, 32'h0, 8'hff, 1'b1);
    wr(`CCI_OFS_CAPS, 32'h14d, 4'hf, 2'h0);
    run_case(32'h007, 32'h0, 32'h0, 8'hff, 1'b1);
    wr(`CCI_OFS_CAPS, 32'h14b, 4'hf, 2'h0);
    run_case(32'h007, 32'h0, 32'h0, 8'hff, 1'b1);
    wr(`CCI_OFS_CAPS, 32'h14f, 4'hf, 2'h0);
    fill_all();
    wr(`CCI_OFS_CMD, 32'h007, 4'hf, 2'h0);
    wr(`CCI_OFS_CMD, 32'h046, 4'hf, 2'h0);
    wr(`CCI_OFS_CMD, 32'h003, 4'hf, 2'h0);
    wr(`CCI_OFS_CMD, 32'h046, 4'hf, 2'h0);
    rd(`CCI_OFS_FILL, 32'hc0, 2'h0);
    rd(`CCI_OFS_STATUS, 32'h0003_0700, 2'h0);
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule // tb_cci_config_inval
